// *** logic/dpr_pkg.sv ***
// package: offsets, field layouts and types of the dma pointer register bank
package dpr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] DPR_IDX_CTRL  = 8'h50;
  localparam logic [7:0] DPR_IDX_DMAPT = 8'h54;
  localparam logic [7:0] DPR_IDX_BCNT  = 8'h56;
  localparam logic [7:0] DPR_IDX_CHID  = 8'h58;
  localparam logic [7:0] DPR_IDX_RCONV = 8'h5c;
  localparam int         DPR_AW        = 12;

  // reset values
  localparam logic [31:0] DPR_DMAPT_RST = 32'h0000_0000;
  localparam logic [11:0] DPR_BCNT_RST  = 12'h000;
  localparam logic [15:0] DPR_RCONV_RST = 16'h0000;
  localparam logic [2:0]  DPR_CTRL_RST  = 3'h1;    // stopped after reset

  // field layout
  localparam int          DPR_BCNT_W    = 12;
  localparam logic [3:0]  DPR_BCNT_RES  = 4'hf;    // reserved bits read ones
  localparam int          DPR_RCODE_LSB = 12;      // encoded length field
  localparam logic [3:0]  DPR_RCODE_MAX = 4'h9;    // longest ring: 512
  localparam int          DPR_CTL_STOP  = 0;
  localparam int          DPR_CTL_SUSP  = 1;
  localparam int          DPR_CTL_BMST  = 2;

  // axi response codes
  localparam logic [1:0]  DPR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  DPR_RESP_SLVERR = 2'h2;

  // increment commands from the bus interface logic
  typedef struct packed {
    logic addr_inc;   // advance pointer by one address
    logic cnt_inc;    // one buffer byte moved
  } dpr_dma_cmd_t;

  // software control bits
  typedef struct packed {
    logic bus_master;
    logic suspend_flag;
    logic stop;
  } dpr_ctrl_t;

endpackage : dpr_pkg

// *** logic/dpr_regs.sv ***
// dma pointer, byte counter, chip id and ring length converter registers
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
module dpr_regs
  import dpr_pkg::*;
#(
  parameter logic [3:0]  REVISION   = 4'h1,      // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0abc,  // arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h055    // arbitrary value
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write address and data
  input  wire logic [DPR_AW-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [DPR_AW-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // bus interface logic side
  input  wire dpr_dma_cmd_t       dma_cmd,
  output logic [31:0]             dma_address_pointer,
  output logic                    dma_address_valid,
  output logic [DPR_BCNT_W-1:0]   buffer_byte_counter,
  output logic                    buffer_done,
  output logic [15:0]             ring_length_count,
  output logic [31:0]             chip_identification
);

  ////////////////////////////////////////////////////////////////////////
  // parameter check

  if (MAKER_CODE == 11'h000) begin : g_bad_maker
    $error("maker code must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // byte address to register index; alignment is checked by mapped, not here
  function automatic logic [7:0] idx_of(input logic [DPR_AW-1:0] a);
    idx_of = a[9:2];
  endfunction : idx_of

  // index is one of the bank's registers
  function automatic logic mapped(input logic [DPR_AW-1:0] a);
    logic [7:0] i;
    i = idx_of(a);
    mapped = (a[1:0] == 2'h0) && (a[DPR_AW-1:10] == '0) &&
             (i == DPR_IDX_CTRL || i == DPR_IDX_DMAPT ||
              i == DPR_IDX_BCNT || i == DPR_IDX_CHID ||
              i == DPR_IDX_RCONV);
  endfunction : mapped

  // byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = m;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [DPR_AW-1:0]     aw_addr_r;
  logic                  aw_held_r;
  logic [31:0]           w_data_r;
  logic [3:0]            w_strb_r;
  logic                  w_held_r;
  logic                  awready_r;
  logic                  wready_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  arready_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_r;
  logic [1:0]            rresp_r;
  dpr_ctrl_t             ctrl_r;
  logic [31:0]           dmapt_r;
  logic                  dma_seen_r;
  logic [DPR_BCNT_W-1:0] bcnt_r;
  logic [15:0]           rconv_r;
  logic                  bm_valid_r;
  logic                  done_r;

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire        aw_take  = s_axi_awvalid & awready_r;
  wire        w_take   = s_axi_wvalid & wready_r;
  wire        ar_take  = s_axi_arvalid & arready_r;
  wire        wr_go    = aw_held_r & w_held_r & ~bvalid_r;
  wire [7:0]  wr_idx   = idx_of(aw_addr_r);
  wire        wr_map   = mapped(aw_addr_r);
  wire [7:0]  rd_idx   = idx_of(s_axi_araddr);
  wire        rd_map   = mapped(s_axi_araddr);
  // software access window for the pointer bank
  wire        sw_open  = ctrl_r.stop | ctrl_r.suspend_flag;
  wire        wr_ok    = wr_go & wr_map & sw_open;
  wire        wr_ctrl  = wr_go & wr_map & (wr_idx == DPR_IDX_CTRL);
  wire        wr_dmapt = wr_ok & (wr_idx == DPR_IDX_DMAPT);
  wire        wr_bcnt  = wr_ok & (wr_idx == DPR_IDX_BCNT);
  wire        wr_rconv = wr_ok & (wr_idx == DPR_IDX_RCONV);
  // id word: fixed fields, bit 0 forced to one; matches scan id
  wire [31:0] chid_w   = {REVISION, PART_CODE, MAKER_CODE,
                          1'b1};

  // merged write values
  wire [31:0] dmapt_m  = merge(dmapt_r, w_data_r, w_strb_r);
  wire [31:0] bcnt_m   = merge({16'h0, DPR_BCNT_RES, bcnt_r},
                               w_data_r, w_strb_r);
  wire [31:0] rconv_m  = merge({16'h0, rconv_r}, w_data_r, w_strb_r);
  wire [31:0] ctrl_m   = merge({29'h0, ctrl_r}, w_data_r, w_strb_r);

  // encoded ring length to negative count, capped at the longest ring
  wire [3:0]  rcode    = rconv_m[DPR_RCODE_LSB +: 4];
  wire [3:0]  rcode_c  = (rcode > DPR_RCODE_MAX) ? DPR_RCODE_MAX : rcode;
  wire [15:0] rlen     = 16'h0001 << rcode_c;
  wire [15:0] rconv_n  = 16'h0 - rlen;

  // read data selection
  wire [31:0] rd_reg   =
    (rd_idx == DPR_IDX_CTRL)  ? {29'h0, ctrl_r} :
    (rd_idx == DPR_IDX_DMAPT) ? dmapt_r :
    (rd_idx == DPR_IDX_BCNT)  ? {16'h0, DPR_BCNT_RES, bcnt_r} :
    (rd_idx == DPR_IDX_CHID)  ? chid_w :
                                {16'h0, rconv_r};
  // bank registers other than control read zero while running
  wire        rd_gate  = sw_open | (rd_idx == DPR_IDX_CTRL);
  wire [31:0] rd_val   = (rd_map & rd_gate) ? rd_reg : 32'h0;
  wire [1:0]  rd_resp  = rd_map ? DPR_RESP_OKAY : DPR_RESP_SLVERR;
  wire [1:0]  wr_resp  = wr_map ? DPR_RESP_OKAY : DPR_RESP_SLVERR;

  ////////////////////////////////////////////////////////////////////////
  // write address and data capture, either order

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // ready flags: one item per channel until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      awready_r <= ~aw_held_r & ~aw_take & ~bvalid_r & ~wr_go;
      wready_r  <= ~w_held_r & ~w_take & ~bvalid_r & ~wr_go;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= DPR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= DPR_RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_r & ~ar_take;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= rd_resp;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits (always writable)

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= DPR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_m[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dma address pointer: software load, else increment

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dmapt_r <= DPR_DMAPT_RST;
    end else if (wr_dmapt) begin
      dmapt_r <= dmapt_m;
    end else if (dma_cmd.addr_inc) begin
      dmapt_r <= dmapt_r + 32'h1;
    end
  end

  // first dma operation seen; a software load in the same cycle
  // must not hide it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_seen_r <= 1'b0;
    end else if (dma_cmd.addr_inc) begin
      dma_seen_r <= 1'b1;
    end
  end

  // pointer valid only in master mode after a dma operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bm_valid_r <= 1'b0;
    end else begin
      bm_valid_r <= ctrl_r.bus_master & dma_seen_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer byte counter: negative count rising toward zero

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_r <= DPR_BCNT_RST;
    end else if (wr_bcnt) begin
      bcnt_r <= bcnt_m[DPR_BCNT_W-1:0];
    end else if (dma_cmd.cnt_inc) begin
      bcnt_r <= bcnt_r + 12'h001;
    end
  end

  // buffer exhausted flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b1;
    end else begin
      done_r <= (bcnt_r == 12'h000);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ring length converter; id word ignores writes

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rconv_r <= DPR_RCONV_RST;
    end else if (wr_rconv) begin
      rconv_r <= rconv_n;
    end
  end

  // id word register; no write strobe reaches it
  logic [31:0] chid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chid_r <= 32'h0;
    end else begin
      chid_r <= chid_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready       = awready_r;
  assign s_axi_wready        = wready_r;
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_arready       = arready_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rdata         = rdata_r;
  assign s_axi_rresp         = rresp_r;
  assign dma_address_pointer = dmapt_r;
  assign dma_address_valid   = bm_valid_r;
  assign buffer_byte_counter = bcnt_r;
  assign buffer_done         = done_r;
  assign ring_length_count   = rconv_r;
  assign chip_identification = chid_r;

endmodule : dpr_regs

// *** verif/dpr_regs_monitor.sv ***
// concurrent checks on the ports of the dma pointer register bank
`timescale 1ns/10ps
module dpr_regs_monitor
  import dpr_pkg::*;
(
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // register bus
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  // bus interface logic side
  input wire dpr_dma_cmd_t          dma_cmd,
  input wire logic [31:0]           dma_address_pointer,
  input wire logic                  dma_address_valid,
  input wire logic [DPR_BCNT_W-1:0] buffer_byte_counter,
  input wire logic                  buffer_done,
  input wire logic [31:0]           chip_identification
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic seen_r;

  // remembers any pointer advance since reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r <= 1'b0;
    end else if (dma_cmd.addr_inc) begin
      seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PTR_INC: assert property (
    dma_cmd.addr_inc ##1 !$rose(s_axi_bvalid)
    |-> dma_address_pointer == $past(dma_address_pointer) + 32'h1)
    else $error("pointer did not advance");
  AST_PTR_HOLD: assert property (
    !dma_cmd.addr_inc ##1 !$rose(s_axi_bvalid)
    |-> $stable(dma_address_pointer)) else $error("pointer moved alone");
  AST_CNT_INC: assert property (
    dma_cmd.cnt_inc ##1 !$rose(s_axi_bvalid)
    |-> buffer_byte_counter == $past(buffer_byte_counter) + 12'h1)
    else $error("byte counter did not advance");
  AST_CNT_HOLD: assert property (
    !dma_cmd.cnt_inc ##1 !$rose(s_axi_bvalid)
    |-> $stable(buffer_byte_counter)) else $error("byte counter moved alone");
  AST_DONE: assert property (1'b1 |=>
    buffer_done == ($past(buffer_byte_counter) == 12'h000))
    else $error("done flag wrong");
  AST_VALID: assert property (dma_address_valid |-> seen_r)
    else $error("pointer valid before any transfer");
  AST_ID_FIXED: assert property ($past(aresetn, 2) |->
    $stable(chip_identification)) else $error("id word changed");
  AST_ID_LSB: assert property (
    $past(aresetn) |-> chip_identification[0])
    else $error("id bit zero low");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");

  // main scenarios reached
  COV_PTR: cover property (dma_cmd.addr_inc);
  COV_CNT: cover property (dma_cmd.cnt_inc ##2 buffer_done);
  COV_VALID: cover property (dma_address_valid);
  COV_RD_STALL: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : dpr_regs_monitor

bind dpr_regs dpr_regs_monitor dpr_regs_monitor_i (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .dma_cmd, .dma_address_pointer,
  .dma_address_valid, .buffer_byte_counter, .buffer_done,
  .chip_identification);

// *** verif/test_dma_pointer_id_ring_regs.sv ***
// self-checking bench for the dma pointer register bank
`timescale 1ns/10ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("MISMATCH %0t %h != %h", $time, (g), (e)); \
  end \
end
module test_dma_pointer_id_ring_regs
  import dpr_pkg::*;
;
  logic         aclk, aresetn, awv, wv, br, arv, rr;
  logic         awr, wrdy, bv, arr, rv, av, bd;
  logic [11:0]  awa, ara, cnt;
  logic [31:0]  wd, rdat, ptr, cid;
  logic [15:0]  rlc, e;
  logic [3:0]   ws;
  logic [1:0]   bre, rre;
  dpr_dma_cmd_t cmd;
  int           err_count, compares;
  // byte addresses; id fields are the design's arbitrary defaults
  localparam logic [11:0] A_CT = {2'h0, DPR_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_PT = {2'h0, DPR_IDX_DMAPT, 2'h0};
  localparam logic [11:0] A_BC = {2'h0, DPR_IDX_BCNT, 2'h0};
  localparam logic [11:0] A_ID = {2'h0, DPR_IDX_CHID, 2'h0};
  localparam logic [11:0] A_RC = {2'h0, DPR_IDX_RCONV, 2'h0};
  localparam logic [31:0] ID = {4'h1, 16'h0abc, 11'h055, 1'b1};
  localparam logic [1:0]  OK = DPR_RESP_OKAY;

  dpr_regs dpr_regs_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bre), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rre),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .dma_cmd(cmd),
    .dma_address_pointer(ptr), .dma_address_valid(av),
    .buffer_byte_counter(cnt), .buffer_done(bd),
    .ring_length_count(rlc), .chip_identification(cid));

  // 25 mhz clock
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  // one write, held until each channel is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    `CHK(bre, er)
  endtask : wr

  // one read, compared with its expected word
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    `CHK(rdat, ed)
    `CHK(rre, er)
  endtask : rd

  // one read whose answer waits two cycles before rready rises
  task automatic rd_slow(input logic [11:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    repeat (2) @(posedge aclk);
    rr <= 1'b1;
    @(posedge aclk);
    rr <= 1'b0;
    `CHK(rdat, ed)
    `CHK(rre, er)
  endtask : rd_slow

  // n back-to-back increment pulses, then settle
  task automatic pulse(input dpr_dma_cmd_t c, input int n);
    repeat (n) begin
      @(posedge aclk);
      cmd <= c;
    end
    @(posedge aclk);
    cmd <= '0;
    repeat (2) @(posedge aclk);
  endtask : pulse

  task automatic test_done;
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    #400000;
    err_count++;
    test_done();
  end

  // main sequence
  initial begin
    {aresetn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    ws = 4'hf;
    cmd = '0;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CT, 32'h1, OK);
    rd(A_ID, ID, OK);
    wr(A_ID, 32'h0, OK);
    rd(A_ID, ID, OK);
    `CHK(cid, ID)
    wr(A_PT, 32'hffff_fffe, OK);
    rd(A_PT, 32'hffff_fffe, OK);
    pulse(2'b10, 3);
    `CHK(ptr, 32'h1)
    `CHK(av, 1'b0)
    wr(A_BC, 32'h0000_0ffd, OK);
    rd(A_BC, 32'h0000_fffd, OK);
    pulse(2'b01, 3);
    `CHK(cnt, 12'h000)
    `CHK(bd, 1'b1)
    // every ring code, clamped above the longest ring
    for (int k = 0; k < 16; k++) begin
      wr(A_RC, {16'h0, 4'(k), 12'h0}, OK);
      e = 16'hffff << ((k > 9) ? 9 : k);
      rd(A_RC, {16'h0, e}, OK);
      `CHK(rlc, e)
    end
    // running: bank closed; suspended bus master: open
    wr(A_CT, 32'h0, OK);
    rd(A_PT, 32'h0, OK);
    rd(A_ID, 32'h0, OK);
    wr(A_PT, 32'h5a5a_0000, OK);
    wr(A_CT, 32'h6, OK);
    rd(A_PT, 32'h1, OK);
    `CHK(av, 1'b1)
    // low two byte lanes only, answer left waiting
    ws <= 4'h3;
    wr(A_PT, 32'h1234_abcd, OK);
    ws <= 4'hf;
    rd_slow(A_PT, 32'h0000_abcd, OK);
    rd(12'h144, 32'h0, DPR_RESP_SLVERR);
    wr(12'h152, 32'h0, DPR_RESP_SLVERR);
    test_done();
  end
endmodule : test_dma_pointer_id_ring_regs
